// [dv/serial_peer.sv]
// Behavioural far-end serial port that captures and sends async frames.
`timescale 1ns/1ps
module serial_peer (
    // Clock.
    input  wire logic clk,
    // Serial lines.
    input  wire logic line_in,
    output logic      line_out
);
    // The line rests at the stop level whenever no frame is being sent.
    initial line_out = 1'b1;

    // Sampling on the falling edge keeps clear of the flop updates.
    task automatic capture(input int period, input int nbits,
                           output logic [15:0] bits, output logic ok);
        int i;
        bits = '0;
        ok = 1'b0;
        for (i = 0; i < 4000 && !ok; i++) begin
            @(negedge clk);
            ok = (line_in === 1'b0);
        end
        if (ok) begin
            repeat (period / 2) @(negedge clk);
            for (i = 0; i < nbits; i++) begin
                bits[i] = line_in;
                if (i < nbits - 1) repeat (period) @(negedge clk);
            end
        end
    endtask : capture

    // Each bit is held for one whole bit period, start bit first.
    task automatic send(input int period, input int nbits,
                        input logic [15:0] bits);
        int i;
        for (i = 0; i < nbits; i++) begin
            @(posedge clk);
            line_out <= bits[i];
            repeat (period - 1) @(posedge clk);
        end
        @(posedge clk);
        line_out <= 1'b1;
    endtask : send
endmodule : serial_peer

// [dv/uart_baud_frame_tb.sv]
// Self-checking bench for the baud reload and frame mode block.
`timescale 1ns/1ps
`include "uart_baud_cfg.svh"
module uart_baud_frame_tb;
    localparam int V_SLOW = 100;
    localparam int V_FAST = 4;
    localparam logic [1:0] TMODE [5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h3};
    localparam logic [7:0] TCTL [5] = '{8'h11, 8'hA1, 8'hD1, 8'h99, 8'hE1};
    localparam logic [7:0] TDAT [5] = '{8'hA5, 8'h53, 8'h96, 8'h3C, 8'hC3};
    localparam logic       TMSB [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    logic       ref_clk, resetn, wr, rd, ext_clk, sin, sot, ser_clk;
    logic [2:0] addr;
    logic [7:0] wdata, rdata;
    int         n_mismatch = 0;
    int         num_checks = 0;

    uart_baud_frame dut (.REF_CLK(ref_clk), .RESETN(resetn), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .EXT_CLK(ext_clk),
        .SIN(sin), .SOT(sot), .SER_CLK(ser_clk));
    serial_peer peer (.clk(ref_clk), .line_in(sot), .line_out(sin));

    // Reference clock at 20 MHz.
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Bus cycles are entered just after a rising edge and leave one later.
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        @(posedge ref_clk);
    endtask : reg_wr

    task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
        @(posedge ref_clk);
    endtask : reg_rd

    task automatic chk_val(input string what, input logic [15:0] exp,
                           input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    task automatic chk_flag(input string what, input logic exp,
                            input logic got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_flag

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    // Expected line bits, start bit in bit 0; returns the frame length.
    function automatic int build(input logic [1:0] md, input logic [7:0] c,
                                 input logic msb, input logic [7:0] d,
                                 output logic [15:0] f);
        int n, k, nd;
        f = '0;
        if (md == 2'h3) begin
            c = 8'h10;
            msb = 1'b0;
        end
        nd = c[`BIT_LEN_EIGHT] ? 8 : 7;
        for (k = 0; k < nd; k++) f[1 + k] = msb ? d[nd - 1 - k] : d[k];
        n = 1 + nd;
        if (md == 2'h1) begin
            f[n] = c[`BIT_ADDR_FLAG];
            n++;
        end else if (c[`BIT_PARITY_EN]) begin
            f[n] = (^(d & (nd == 8 ? 8'hFF : 8'h7F))) ^ c[`BIT_PARITY_ODD];
            n++;
        end
        f[n] = 1'b1;
        n = n + (c[`BIT_STOP_TWO] ? 2 : 1);
        f[n - 1] = 1'b1;
        return n;
    endfunction : build

    // A hang anywhere ends the run through the same closing report.
    initial begin
        repeat (100000) @(posedge ref_clk);
        n_mismatch++;
        report_and_stop();
    end

    // Main sequence: reset, counters, clock source, frames, abort.
    initial begin
        logic [7:0] c1, c2;
        logic [15:0] got, exp_f;
        logic ok, prev;
        int n, i, k, t, f1;
        {resetn, wr, rd, ext_clk, addr, wdata} = '0;
        repeat (6) @(posedge ref_clk);
        resetn <= 1'b1;
        @(posedge ref_clk);
        reg_rd(`ADDR_RELOAD_LOW, c1);
        reg_rd(`ADDR_RELOAD_HIGH, c2);
        chk_val("count at reset", 16'h0000, {c2, c1});
        repeat (10) @(posedge ref_clk);
        reg_rd(`ADDR_RELOAD_LOW, c1);
        chk_val("stopped count", 16'h0000, {8'h00, c1});
        chk_flag("idle line", 1'b1, sot);
        // Internal clock, reload of one hundred.
        reg_wr(`ADDR_RELOAD_HIGH, 8'h00);
        reg_wr(`ADDR_RELOAD_LOW, 8'h64);
        repeat (20) @(posedge ref_clk);
        reg_rd(`ADDR_RELOAD_LOW, c1);
        reg_rd(`ADDR_RELOAD_LOW, c2);
        chk_flag("count running", 1'b1, c1 < 8'h64);
        chk_val("count step", 16'((c1 >= 2) ? c1 - 2 : c1 + V_SLOW - 1),
                {8'h00, c2});
        repeat (40) @(posedge ref_clk);
        reg_wr(`ADDR_MODE, 8'h40);
        reg_rd(`ADDR_RELOAD_LOW, c1);
        chk_flag("restart", 1'b1, c1 >= 8'h60 && c1 <= 8'h64);
        repeat (40) @(posedge ref_clk);
        reg_wr(`ADDR_MODE, 8'h80);
        reg_rd(`ADDR_RELOAD_LOW, c1);
        chk_flag("soft reset", 1'b1, c1 >= 8'h5F && c1 <= 8'h64);
        // External clock: the count moves only on its rising edges.
        reg_wr(`ADDR_MODE, 8'h20);
        reg_wr(`ADDR_RELOAD_LOW, 8'h64);
        repeat (5) @(posedge ref_clk);
        reg_rd(`ADDR_RELOAD_LOW, c1);
        chk_val("ext held", 16'h0064, {8'h00, c1});
        repeat (3) begin
            ext_clk <= 1'b1;
            repeat (4) @(posedge ref_clk);
            ext_clk <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
        repeat (4) @(posedge ref_clk);
        reg_rd(`ADDR_RELOAD_LOW, c1);
        chk_val("ext ticks", 16'h0061, {8'h00, c1});
        // Fast internal rate for the serial clock and frames.
        reg_wr(`ADDR_MODE, 8'h00);
        reg_wr(`ADDR_RELOAD_LOW, 8'(V_FAST));
        {n, f1, t} = '0;
        prev = 1'b1;
        for (i = 0; i < 400 && n < 2; i++) begin
            @(negedge ref_clk);
            if (prev === 1'b1 && ser_clk === 1'b0) begin
                n++;
                t = i - f1;
                f1 = i;
            end
            prev = ser_clk;
        end
        @(posedge ref_clk);
        chk_val("ser clk period", 16'(V_FAST + 1), 16'(t));
        for (k = 0; k < 5; k++) begin
            reg_wr(`ADDR_MODE, {6'h00, TMODE[k]});
            reg_wr(`ADDR_CONTROL, TCTL[k]);
            reg_wr(`ADDR_STATUS, {5'h00, TMSB[k], 2'h0});
            n = build(TMODE[k], TCTL[k], TMSB[k], TDAT[k], exp_f);
            reg_wr(`ADDR_TXDATA, TDAT[k]);
            peer.capture(V_FAST + 1, n, got, ok);
            chk_flag("tx start", 1'b1, ok);
            if (!ok) report_and_stop();
            chk_val("tx frame", exp_f, got);
            repeat (15) @(posedge ref_clk);
        end
        // Reception; data is read before reception is switched off.
        reg_wr(`ADDR_MODE, 8'h00);
        reg_wr(`ADDR_CONTROL, 8'h13);
        reg_wr(`ADDR_STATUS, 8'h00);
        n = build(2'h0, 8'h13, 1'b0, 8'h3C, exp_f);
        peer.send(V_FAST + 1, n, exp_f);
        for (i = 0; i < 20; i++) begin
            reg_rd(`ADDR_STATUS, c1);
            if (c1[1] === 1'b1) break;
        end
        chk_flag("rx full", 1'b1, c1[1]);
        reg_rd(`ADDR_RXDATA, c1);
        chk_val("rx data", 16'h003C, {8'h00, c1});
        reg_rd(`ADDR_STATUS, c1);
        chk_flag("rx full cleared", 1'b0, c1[1]);
        reg_wr(`ADDR_CONTROL, 8'h11);
        // A mode change in mid-frame must return the line to idle.
        reg_wr(`ADDR_TXDATA, 8'h00);
        for (i = 0; i < 100 && sot !== 1'b0; i++) @(negedge ref_clk);
        chk_flag("abort frame started", 1'b0, sot);
        @(posedge ref_clk);
        repeat (6) @(posedge ref_clk);
        reg_wr(`ADDR_MODE, {6'h00, uart_baud_pkg::MODE_SYNC});
        repeat (2) @(posedge ref_clk);
        t = 0;
        repeat (60) begin
            @(negedge ref_clk);
            if (sot !== 1'b1) t++;
        end
        chk_val("low bits after abort", 16'h0000, 16'(t));
        report_and_stop();
    end
endmodule : uart_baud_frame_tb

// [hdl/uart_baud_frame.sv]
// Baud reload counters, operating mode select and async frame engine.
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "uart_baud_cfg.svh"
// What this block does
// - Serial clock falls after (V+1)/2 counts.
// - Two 15-bit reload counters, internal or external.
// - Reload register read returns transmit count.
// - Writing reload value starts both counters.
// - Soft reset or restart bit restarts both.
// - Restart bit reloads counters next clock.
// - Receive counter restarts on start edge.
// - Reset clears reload and counter, stopped.
// - Soft reset zeroes counter then resumes.
// - Restart reloads without zeroing counter.
// - Mode field selects four operating modes.
// - LIN forces 8N1 least bit first.
// - Mode change aborts transfers, goes idle.
// - Frame: low start, data, high stop.
// - Direction bit selects LSB or MSB first.
// - Parity sits between data and stop.
// - Normal mode: 7/8 data, parity, 1/2 stop.
// - Multiprocessor: data plus flag, no parity.
// - Length is 1 + d + p + s bits.
// - Bit rate is source over reload plus one.
module uart_baud_frame (
    // Clock and reset.
    input  wire logic        REF_CLK,
    input  wire logic        RESETN,
    // Register port.
    input  wire logic [2:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    // Serial pins.
    input  wire logic        EXT_CLK,
    input  wire logic        SIN,
    output logic             SOT,
    output logic             SER_CLK
);
    // Register state.
    logic [14:0] reload;
    logic [14:0] tx_count;
    logic [14:0] rx_count;
    logic        running;
    logic [7:0]  mode_reg;
    logic [7:0]  ctrl_reg;
    logic        msb_first;
    logic [7:0]  tx_data;
    logic        tx_pending;
    logic [7:0]  rx_data;
    logic        rx_full;
    // Serial state.
    uart_baud_pkg::tx_state_e tx_state;
    uart_baud_pkg::rx_state_e rx_state;
    logic [11:0] tx_shift;
    logic [3:0]  tx_left;
    logic [3:0]  rx_left;
    logic [8:0]  rx_shift;
    logic [2:0]  ext_sync;
    logic        ext_level;
    logic        ext_prev;
    logic [2:0]  sin_sync;
    logic        sin_level;
    logic        sin_prev;

    // Picks the data bit order; returns the byte as it goes on the wire.
    function automatic logic [7:0] order_bits(input logic [7:0] d,
                                              input logic msb,
                                              input logic eight);
        logic [7:0] r;
        r = d;
        if (msb) begin
            for (int i = 0; i < 8; i++) begin
                r[i] = d[7 - i];
            end
            if (!eight) begin
                r = {1'b0, r[7:1]};
            end
        end
        return r;
    endfunction : order_bits

    // Decoded writes and mode fields.
    wire wr_low     = WR && (ADDR == `ADDR_RELOAD_LOW);
    wire wr_high    = WR && (ADDR == `ADDR_RELOAD_HIGH);
    wire wr_mode    = WR && (ADDR == `ADDR_MODE);
    wire wr_ctrl    = WR && (ADDR == `ADDR_CONTROL);
    wire wr_status  = WR && (ADDR == `ADDR_STATUS);
    wire wr_tx      = WR && (ADDR == `ADDR_TXDATA);
    wire rd_rx      = RD && (ADDR == `ADDR_RXDATA);
    wire soft_reset = wr_mode && WDATA[`BIT_SOFT_RESET];
    wire restart    = wr_mode && WDATA[`BIT_RESTART];
    wire [1:0] next_mode_bits = {WDATA[`BIT_MODE_HI], WDATA[`BIT_MODE_LO]};
    wire mode_change = wr_mode &&
        (next_mode_bits != mode_reg[`BIT_MODE_HI:`BIT_MODE_LO]);
    uart_baud_pkg::op_mode_e op_mode;
    assign op_mode = uart_baud_pkg::op_mode_e'(
        mode_reg[`BIT_MODE_HI:`BIT_MODE_LO]);
    wire is_lin   = (op_mode == uart_baud_pkg::MODE_LIN);
    wire is_multi = (op_mode == uart_baud_pkg::MODE_MULTI);
    wire is_async = (op_mode != uart_baud_pkg::MODE_SYNC);
    wire abort    = mode_change || soft_reset;

    // Effective frame format; LIN overrides parity enable, stop count, length and direction.
    uart_baud_pkg::frame_fmt_s fmt;
    assign fmt.parity_en  = !is_lin && !is_multi &&
                            ctrl_reg[`BIT_PARITY_EN];
    assign fmt.parity_odd = ctrl_reg[`BIT_PARITY_ODD];
    assign fmt.stop_two   = !is_lin &&
                            ctrl_reg[`BIT_STOP_TWO];
    assign fmt.len_eight  = is_lin ||
                            ctrl_reg[`BIT_LEN_EIGHT];
    assign fmt.addr_flag  = ctrl_reg[`BIT_ADDR_FLAG];
    assign fmt.msb_first  = !is_lin && msb_first;

    // Source clock tick: external edge after three flops, or every cycle.
    wire ext_sel  = mode_reg[`BIT_EXT_CLK];
    wire ext_rise = ext_level && !ext_prev;
    wire tick     = ext_sel ? ext_rise : 1'b1;
    wire [14:0] half = 15'((16'(reload) + 16'h0001) >> 1);
    wire tx_wrap  = running && tick && (tx_count == `RELOAD_ZERO);
    wire rx_wrap  = running && tick && (rx_count == `RELOAD_ZERO);
    wire rx_mid   = running && tick && (rx_count == half);
    wire start_edge = is_async && (rx_state == uart_baud_pkg::RX_IDLE) &&
                      ctrl_reg[`BIT_RX_EN] && sin_prev && !sin_level;

    // Input synchronisers; a change counts when stages two and three agree.
    always_ff @(posedge REF_CLK) begin
        ext_sync <= {ext_sync[1:0], EXT_CLK};
        sin_sync <= {sin_sync[1:0], SIN};
        if (!RESETN) begin
            ext_level <= 1'b0;
            sin_level <= 1'b1;
            ext_prev  <= 1'b0;
            sin_prev  <= 1'b1;
        end else begin
            if (ext_sync[1] == ext_sync[2]) ext_level <= ext_sync[2];
            if (sin_sync[1] == sin_sync[2]) sin_level <= sin_sync[2];
            ext_prev <= ext_level;
            sin_prev <= sin_level;
        end
    end

    // Reload value; a write to the pair starts counting.
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            reload  <= `RELOAD_ZERO;
            running <= 1'b0;
        end else begin
            if (wr_low) reload[7:0] <= WDATA;
            if (wr_high) reload[14:8] <= WDATA[6:0];
            if (wr_low || wr_high) running <= 1'b1;
        end
    end

    // Transmit counter: soft reset zeroes it, restart reloads it.
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            tx_count <= `RELOAD_ZERO;
        end else if (soft_reset) begin
            tx_count <= `RELOAD_ZERO;
        end else if (restart || wr_low || wr_high) begin
            tx_count <= reload;
        end else if (running && tick) begin
            tx_count <= tx_wrap ? reload : tx_count - 15'h0001;
        end
    end

    // Receive counter: also realigned by a start bit edge.
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            rx_count <= `RELOAD_ZERO;
        end else if (soft_reset) begin
            rx_count <= `RELOAD_ZERO;
        end else if (restart || start_edge || wr_low || wr_high) begin
            rx_count <= reload;
        end else if (running && tick) begin
            rx_count <= rx_wrap ? reload : rx_count - 15'h0001;
        end
    end

    // Serial clock: low once half the period has been counted.
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            SER_CLK <= 1'b1;
        end else if (tx_wrap) begin
            SER_CLK <= 1'b1;
        end else if (running && tick && tx_count == half) begin
            SER_CLK <= 1'b0;
        end
    end

    // Mode, control and direction registers.
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            mode_reg  <= 8'h00;
            ctrl_reg  <= 8'h00;
            msb_first <= 1'b0;
        end else begin
            if (wr_mode) mode_reg <= {2'b00, WDATA[5:0]};
            if (wr_ctrl) ctrl_reg <= WDATA;
            if (wr_status) msb_first <= WDATA[`BIT_MSB_FIRST];
        end
    end

    // Frame as sent first bit in bit 0: start, data, flag or parity, stop.
    wire [7:0] wire_data = order_bits(tx_data, fmt.msb_first, fmt.len_eight);
    wire       par_bit   = (fmt.len_eight ? ^tx_data : ^tx_data[6:0]) ^
                           fmt.parity_odd;
    wire       extra_bit = is_multi ? fmt.addr_flag : par_bit;
    wire       has_extra = is_multi || fmt.parity_en;
    wire [3:0] data_n    = fmt.len_eight ? 4'h8 : 4'h7;
    wire [3:0] frame_n   = 4'(4'h1 + data_n + {3'b000, has_extra} +
                           (fmt.stop_two ? 4'h2 : 4'h1));
    // Without an extra bit its slot is the first stop bit, so it must be high.
    wire [11:0] frame_lsb = {3'b111, has_extra ? extra_bit : 1'b1, wire_data};
    wire [11:0] frame_bits = fmt.len_eight ? {frame_lsb[10:0], 1'b0} :
        {3'b111, has_extra ? extra_bit : 1'b1, wire_data[6:0],
         1'b0};

    // Transmitter: holding byte then shifter, one bit per period.
    always_ff @(posedge REF_CLK) begin
        if (!RESETN || abort) begin
            tx_state   <= uart_baud_pkg::TX_IDLE;
            tx_pending <= 1'b0;
            tx_shift   <= 12'hFFF;
            tx_left    <= 4'h0;
            SOT        <= 1'b1;
            tx_data    <= 8'h00;
        end else begin
            if (wr_tx) begin
                tx_data    <= WDATA;
                tx_pending <= 1'b1;
            end
            unique case (tx_state)
                uart_baud_pkg::TX_IDLE: begin
                    SOT <= 1'b1;
                    if (tx_pending && !wr_tx && tx_wrap && is_async &&
                        ctrl_reg[`BIT_TX_EN]) begin
                        tx_shift   <= {1'b1, frame_bits[11:1]};
                        tx_left    <= 4'(frame_n - 4'h1);
                        SOT        <= frame_bits[0];
                        tx_pending <= 1'b0;
                        tx_state   <= uart_baud_pkg::TX_SHIFT;
                    end
                end
                uart_baud_pkg::TX_SHIFT: begin
                    if (tx_wrap) begin
                        if (tx_left == 4'h0) begin
                            SOT      <= 1'b1;
                            tx_state <= uart_baud_pkg::TX_IDLE;
                        end else begin
                            SOT      <= tx_shift[0];
                            tx_shift <= {1'b1, tx_shift[11:1]};
                            tx_left  <= tx_left - 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    // Receiver samples mid bit; start edge realigns the counter.
    // An extra bit shifts one more place, so the data sits one lower.
    wire [8:0] rx_align = has_extra ? {rx_shift[7:0], 1'b0} : rx_shift;
    wire [7:0] rx_raw = fmt.len_eight ? rx_align[8:1] :
                        {1'b0, rx_align[8:2]};
    wire [7:0] rx_word = order_bits(rx_raw, fmt.msb_first, fmt.len_eight);
    wire [3:0] rx_n = 4'(data_n + {3'b000, has_extra} + 4'h1);
    always_ff @(posedge REF_CLK) begin
        if (!RESETN || abort) begin
            rx_state <= uart_baud_pkg::RX_IDLE;
            rx_left  <= 4'h0;
            rx_shift <= 9'h000;
            rx_data  <= 8'h00;
            rx_full  <= 1'b0;
        end else begin
            if (rd_rx) rx_full <= 1'b0;
            unique case (rx_state)
                uart_baud_pkg::RX_IDLE: begin
                    if (start_edge) begin
                        rx_left  <= rx_n;
                        rx_state <= uart_baud_pkg::RX_SHIFT;
                    end
                end
                uart_baud_pkg::RX_SHIFT: begin
                    if (rx_mid) begin
                        if (rx_left == 4'h0) begin
                            rx_data  <= rx_word;
                            rx_full  <= 1'b1;
                            rx_state <= uart_baud_pkg::RX_IDLE;
                        end else begin
                            rx_shift <= {sin_level, rx_shift[8:1]};
                            rx_left  <= rx_left - 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    // Read mux; the reload pair reads back the live transmit count.
    logic [7:0] next_rdata;
    assign next_rdata =
        (ADDR == `ADDR_RELOAD_LOW)  ? tx_count[7:0] :
        (ADDR == `ADDR_RELOAD_HIGH) ? {1'b0, tx_count[14:8]} :
        (ADDR == `ADDR_MODE)        ? {2'b00, mode_reg[5:0]} :
        (ADDR == `ADDR_CONTROL)     ? ctrl_reg :
        (ADDR == `ADDR_STATUS)      ? {5'h00, msb_first, rx_full,
                                       tx_pending} :
        (ADDR == `ADDR_RXDATA)      ? rx_data : 8'h00;
    always_ff @(posedge REF_CLK) begin
        if (!RESETN) RDATA <= 8'h00;
        else RDATA <= RD ? next_rdata : 8'h00;
    end

    // Checks on counter and frame behaviour.
    sequence s_restart;
        RESETN && restart && !soft_reset;
    endsequence
    a_restart_reload: assert property (@(posedge REF_CLK) disable iff
        (!RESETN) s_restart |=> tx_count == $past(reload))
        else $error("Restart did not reload the counter.");
    a_soft_zero: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        soft_reset |=> tx_count == `RELOAD_ZERO)
        else $error("Soft reset did not zero the counter.");
    a_count_down: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        running && tick && tx_count != 0 && !restart && !soft_reset &&
        !wr_low && !wr_high |=> tx_count == $past(tx_count) - 15'h0001)
        else $error("Transmit counter did not count down.");
    a_read_count: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        RD && ADDR == `ADDR_RELOAD_LOW |=> RDATA == $past(tx_count[7:0]))
        else $error("Reload read did not return count.");
    a_start_align: assert property (@(posedge REF_CLK) disable iff
        (!RESETN) start_edge && !soft_reset |=> rx_count == $past(reload))
        else $error("Start edge did not restart receive counter.");
    a_abort_idle: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        mode_change |=> tx_state == uart_baud_pkg::TX_IDLE && SOT)
        else $error("Mode change did not abort transmit.");
    a_lin_format: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        is_lin |-> frame_n == `MIN_BITS + 4'h1 && !fmt.msb_first)
        else $error("LIN frame format not forced.");
    a_frame_len: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        frame_n <= `MAX_BITS && frame_n >= `MIN_BITS)
        else $error("Frame length out of range.");
    a_start_low: assert property (@(posedge REF_CLK) disable iff (!RESETN)
        tx_state == uart_baud_pkg::TX_IDLE ##1
        tx_state == uart_baud_pkg::TX_SHIFT |-> !SOT)
        else $error("Frame did not begin with a low start bit.");
endmodule : uart_baud_frame

// [inc/uart_baud_cfg.svh]
// Constants for the baud reload and frame mode block.
`ifndef UART_BAUD_CFG_SVH
`define UART_BAUD_CFG_SVH
`define ADDR_RELOAD_LOW   3'h0
`define ADDR_RELOAD_HIGH  3'h1
`define ADDR_MODE         3'h2
`define ADDR_CONTROL      3'h3
`define ADDR_STATUS       3'h4
`define ADDR_TXDATA       3'h5
`define ADDR_RXDATA       3'h6
`define BIT_SOFT_RESET    7
`define BIT_RESTART       6
`define BIT_EXT_CLK       5
`define BIT_MODE_HI       1
`define BIT_MODE_LO       0
`define BIT_PARITY_EN     7
`define BIT_PARITY_ODD    6
`define BIT_STOP_TWO      5
`define BIT_LEN_EIGHT     4
`define BIT_ADDR_FLAG     3
`define BIT_RX_EN         1
`define BIT_TX_EN         0
`define BIT_MSB_FIRST     2
`define RELOAD_ZERO       15'h0000
`define MIN_BITS          4'h9
`define MAX_BITS          4'hC
`endif

// [inc/uart_baud_pkg.sv]
// Types shared by the baud reload and frame mode block.
package uart_baud_pkg;
    typedef enum logic [1:0] {
        MODE_ASYNC,
        MODE_MULTI,
        MODE_SYNC,
        MODE_LIN
    } op_mode_e;

    typedef struct packed {
        logic parity_en;
        logic parity_odd;
        logic stop_two;
        logic len_eight;
        logic addr_flag;
        logic msb_first;
    } frame_fmt_s;

    typedef enum {
        TX_IDLE,
        TX_SHIFT
    } tx_state_e;

    typedef enum {
        RX_IDLE,
        RX_SHIFT
    } rx_state_e;
endpackage : uart_baud_pkg
